// >>> verilog/xmode_pkg.sv
/*
  Constants and carrier types for the external expansion mode select block.
  Assumes a single system clock domain and a peripheral I/O access port
  with byte and single-bit write strobes.
*/
// Contract
// R1: Hold bit 1 makes hold pins bus handshake.
// R2: Size 011 selects 64K, address/data on ports.
// R3: Expansion mode gives control port bus strobes.
// R4: Size 100 selects 256K expansion space.
// R5: Size 101 selects 1M expansion space; the upper address port still drives only bus_addr[17:16].
// R6: Size 11x selects 4M expansion space; the upper address port still drives only bus_addr[17:16].
// R7: Size 000 plain ports; others reserved.
// R8: Register resets 00H, bit and byte access.
// R9: Program counter upper eight bits stay zero.
// R10: Data address decodes only 24 bits.
// R11: Bit 23 sign-extends data address to 32.
// R12: Zero register always reads zero.
// R13: Port pins are inputs after reset.
// R14: Hold bit 0 keeps hold pins as ports.
// R15: Software sets control latch bits 3,4 first.
// R16: Undecoded upper bits show repeated images.
// R17: Mode change applies from next bus cycle.
package xmode_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_REG_ADDR   = 32'hffff_f04c;
  localparam logic [7:0]  MODE_REG_RESET  = 8'h00;
  localparam int          HOLD_BIT_POS    = 3;
  localparam int          SIZE_LSB_POS    = 0;
  localparam logic [7:0]  MODE_WR_MASK    = 8'h0f;

  // ----------------------------------------------------------------
  // Space sizes and address widths
  // ----------------------------------------------------------------
  localparam int PHYS_ADDR_W  = 24;
  localparam int SIGN_BIT_POS = 23;
  localparam logic [23:0] MASK_64K  = 24'h00_ffff;
  localparam logic [23:0] MASK_256K = 24'h03_ffff;
  localparam logic [23:0] MASK_1M   = 24'h0f_ffff;
  localparam logic [23:0] MASK_4M   = 24'h3f_ffff;

  typedef enum logic [2:0] {
    SPACE_NONE, SPACE_64K, SPACE_256K, SPACE_1M, SPACE_4M, SPACE_RSVD
  } space_t;

  typedef struct packed {
    logic   hold_pins_bus;
    logic   expansion;
    space_t space;
  } pin_mode_t;

  typedef struct packed {
    logic lower_byte_enable;
    logic upper_byte_enable;
    logic read_write;
    logic data_strobe;
    logic address_strobe;
    logic write_strobe_low;
    logic write_strobe_high;
    logic read_strobe;
  } bus_ctrl_t;

endpackage

// >>> verilog/space_decode.sv
/*
  Decodes the space-size field of the expansion mode register into the
  selected space and pin mode. Purely combinational.
*/
`timescale 1ns/1ps
module space_decode
  import xmode_pkg::*;
(
  input  wire logic [7:0]          mode_reg,
  output xmode_pkg::pin_mode_t     pin_mode
);
  import xmode_pkg::*;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic space_t size_decode(input logic [2:0] f);
    case (f)
      3'b000:  size_decode = SPACE_NONE; // R7
      3'b011:  size_decode = SPACE_64K;  // R2
      3'b100:  size_decode = SPACE_256K; // R4
      3'b101:  size_decode = SPACE_1M;   // R5
      3'b110,
      3'b111:  size_decode = SPACE_4M;   // R6
      default: size_decode = SPACE_RSVD; // R7
    endcase
  endfunction

  always_comb begin
    pin_mode.space         = size_decode(mode_reg[SIZE_LSB_POS +: 3]);
    // Reserved codes are treated as plain ports so pins never float undefined.
    pin_mode.expansion     = !(pin_mode.space inside {SPACE_NONE, SPACE_RSVD});
    pin_mode.hold_pins_bus = mode_reg[HOLD_BIT_POS]; // R1 R14
  end

endmodule

// >>> verilog/external_expansion_mode_select.sv
/*
  Expansion mode register and pin function multiplexer for ports 4, 5, 6
  and the control port, plus the address shaping for fetch and data.
  Assumes the CPU presents peripheral writes with byte and bit strobes and
  marks bus cycle starts with bus_cycle_start; external pins are synchronised.
*/
`timescale 1ns/1ps
module external_expansion_mode_select
  import xmode_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [31:0]            io_addr,
  input  wire logic                   io_wr_byte,
  input  wire logic                   io_wr_bit,
  input  wire logic [2:0]             io_bit_sel,
  input  wire logic [7:0]             io_wdata,
  input  wire logic                   io_rd,
  output logic [7:0]                  io_rdata,
  output logic                        io_hit,
  input  wire logic                   bus_cycle_start,
  input  wire logic [31:0]            bus_addr,
  input  wire logic [15:0]            bus_wdata,
  input  wire logic                   bus_drive_data,
  input  wire xmode_pkg::bus_ctrl_t   bus_ctrl,
  input  wire logic                   hold_acknowledge_out,
  output logic                        hold_request_in,
  input  wire logic [31:0]            pc_next,
  output logic [31:0]                 pc_fetch,
  input  wire logic [31:0]            data_addr,
  output logic [31:0]                 data_addr_ext,
  output logic [23:0]                 ext_phys_addr,
  input  wire logic [4:0]             reg_sel,
  input  wire logic [31:0]            reg_value,
  output logic [31:0]                 reg_operand,
  input  wire logic [7:0]             port_latch [4],
  input  wire logic [7:0]             port_dir_out [4],
  input  wire logic [7:0]             pin_in [4],
  output logic [7:0]                  pin_out [4],
  output logic [7:0]                  pin_oe [4],
  output logic [7:0]                  port_read [4],
  output xmode_pkg::pin_mode_t        active_mode
);
  import xmode_pkg::*;

  // Port indices: 0 and 1 carry address/data, 2 upper address, 3 control.
  localparam int P_AD_LO = 0;
  localparam int P_AD_HI = 1;
  localparam int P_AHI   = 2;
  localparam int P_CTL   = 3;
  localparam int HOLD_ACK_PIN = 5;
  localparam int HOLD_REQ_PIN = 6;

  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic       sel;
  pin_mode_t  reg_mode;
  pin_mode_t  active_ff;
  logic [7:0] pin_s1_ff [4];
  logic [7:0] pin_s2_ff [4];
  logic [23:0] space_mask;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  assign sel = (io_addr == MODE_REG_ADDR);

  always_comb begin
    nxt_mode = mode_ff;
    if (io_wr_byte) begin
      nxt_mode = io_wdata;
    end else if (io_wr_bit) begin
      nxt_mode[io_bit_sel] = io_wdata[0];
    end
    // Upper four bits are fixed to zero.
    nxt_mode = nxt_mode & MODE_WR_MASK;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_REG_RESET; // R8
    end else if (sel && (io_wr_byte || io_wr_bit)) begin
      mode_ff <= nxt_mode; // R8
    end
  end

  assign io_hit   = sel;
  assign io_rdata = (sel && io_rd) ? mode_ff : 8'h00;

  space_decode u_dec (
    .mode_reg (mode_ff),
    .pin_mode (reg_mode)
  );

  // A cycle already on the pins keeps its mapping; the new one waits.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_ff <= '{hold_pins_bus: 1'b0, expansion: 1'b0, space: SPACE_NONE};
    end else if (bus_cycle_start) begin
      active_ff <= reg_mode; // R17
    end
  end

  assign active_mode = active_ff;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        pin_s1_ff[i] <= 8'h00;
        pin_s2_ff[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        pin_s1_ff[i] <= pin_in[i];
        pin_s2_ff[i] <= pin_s1_ff[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------
  // The port latches reset to zero and direction to input, so all pins
  // come up undriven; reads show pin levels, not the stored zero.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_out[i]   = port_latch[i];
      pin_oe[i]    = port_dir_out[i]; // R13
      port_read[i] = pin_s2_ff[i];    // R13
    end
    if (active_ff.expansion) begin
      pin_out[P_AD_LO] = bus_drive_data ? bus_wdata[7:0] : bus_addr[7:0]; // R2
      pin_oe[P_AD_LO]  = {8{bus_drive_data | bus_ctrl.address_strobe}};
      pin_out[P_AD_HI] = bus_drive_data ? bus_wdata[15:8] : bus_addr[15:8]; // R2
      pin_oe[P_AD_HI]  = {8{bus_drive_data | bus_ctrl.address_strobe}};
      pin_out[P_AHI]   = {6'h00, bus_addr[17:16]}; // R2
      pin_oe[P_AHI]    = 8'h03;
      // The hold pins must stay ports while hold mode is off, so each write strobe
      // shares its byte lane's enable pin. Both are active low, so the pin falls when either does.
      pin_out[P_CTL][4:0] = {bus_ctrl.lower_byte_enable & bus_ctrl.write_strobe_low,
                             bus_ctrl.upper_byte_enable & bus_ctrl.write_strobe_high,
                             bus_ctrl.read_write, bus_ctrl.data_strobe,
                             bus_ctrl.address_strobe}; // R3
      pin_out[P_CTL][7]   = bus_ctrl.read_strobe; // R3
      pin_oe[P_CTL][4:0]  = 5'h1f;
      pin_oe[P_CTL][7]    = 1'b1;
    end
    // Without hold mode the hold pins keep their port defaults from above.
    if (active_ff.hold_pins_bus) begin
      pin_out[P_CTL][HOLD_ACK_PIN] = hold_acknowledge_out; // R1
      pin_oe[P_CTL][HOLD_ACK_PIN]  = 1'b1;
      pin_oe[P_CTL][HOLD_REQ_PIN]  = 1'b0; // R1
    end
  end

  assign hold_request_in = active_ff.hold_pins_bus & pin_s2_ff[P_CTL][HOLD_REQ_PIN]; // R1 R14

  // ----------------------------------------------------------------
  // Address shaping
  // ----------------------------------------------------------------
  always_comb begin
    case (active_ff.space)
      SPACE_64K:  space_mask = MASK_64K;
      SPACE_256K: space_mask = MASK_256K;
      SPACE_1M:   space_mask = MASK_1M;
      SPACE_4M:   space_mask = MASK_4M;
      default:    space_mask = 24'h00_0000;
    endcase
  end

  assign pc_fetch      = {8'h00, pc_next[PHYS_ADDR_W-1:0]}; // R9
  assign data_addr_ext = {{8{data_addr[SIGN_BIT_POS]}}, data_addr[PHYS_ADDR_W-1:0]}; // R10 R11
  assign ext_phys_addr = data_addr[PHYS_ADDR_W-1:0] & space_mask; // R16
  assign reg_operand   = (reg_sel == 5'h00) ? 32'h0000_0000 : reg_value; // R12

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_value: assert property (@(posedge ref_clk) $fell(rst) |-> mode_ff == 8'h00) // R8
    else $error("mode register not zero after reset");
  a_upper_zero: assert property (@(posedge ref_clk) disable iff (rst) mode_ff[7:4] == 4'h0) // R8
    else $error("mode register upper bits set");
  a_mode_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_cycle_start |=> $stable(active_ff)) // R17
    else $error("pin mode changed mid cycle");
  a_mode_loads: assert property (@(posedge ref_clk) disable iff (rst)
    bus_cycle_start |=> active_ff == $past(reg_mode)) // R17
    else $error("pin mode not taken at cycle start");
  a_pc_upper: assert property (@(posedge ref_clk) disable iff (rst) pc_fetch[31:24] == 8'h00) // R9
    else $error("fetch upper bits not zero");
  a_sign_ext: assert property (@(posedge ref_clk) disable iff (rst)
    data_addr_ext[31:24] == {8{data_addr[23]}}) // R11
    else $error("data address not sign extended");
  a_zero_reg: assert property (@(posedge ref_clk) disable iff (rst)
    reg_sel == 5'h00 |-> reg_operand == 32'h0000_0000) // R12
    else $error("zero register not zero");
  a_hold_port: assert property (@(posedge ref_clk) disable iff (rst)
    !active_ff.hold_pins_bus |-> !hold_request_in) // R14
    else $error("hold request while hold pins are ports");
  a_hold_pins_free: assert property (@(posedge ref_clk) disable iff (rst) // R14
    !active_ff.hold_pins_bus |-> pin_oe[P_CTL][6:5] == port_dir_out[P_CTL][6:5])
    else $error("hold pins taken while hold mode is off");
  a_plain_port: assert property (@(posedge ref_clk) disable iff (rst)
    !active_ff.expansion && !active_ff.hold_pins_bus |-> pin_oe[P_AD_LO] == port_dir_out[P_AD_LO]) // R7
    else $error("port pins taken while in port mode");

endmodule

// >>> tb/ext_bus_model.sv
/*
  Behavioural far side of the expansion pins: driven-pin echo and a hold requester.
  Assumes pin_oe high means the block drives that pin.
*/
`timescale 1ns/1ps
module ext_bus_model (
  input  wire logic       ref_clk,
  input  wire logic       hold_req,
  input  wire logic [7:0] pin_out [4],
  input  wire logic [7:0] pin_oe  [4],
  output logic      [7:0] pin_in  [4]
);
  // A released pin shows a changing pattern, so a stale value never looks right.
  logic [7:0] idle_ff = 8'h5a;

  always @(posedge ref_clk) begin
    idle_ff <= idle_ff + 8'h01;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = (pin_out[i] & pin_oe[i]) | (~idle_ff & ~pin_oe[i]);
    end
    if (!pin_oe[3][6]) begin
      pin_in[3][6] = hold_req;
    end
  end
endmodule

// >>> tb/test_external_expansion_mode_select.sv
/*
  Self-checking bench: a table of mode codes, then hand-written cases.
  Assumes xmode_pkg and ext_bus_model are compiled before it.
*/
`timescale 1ns/1ps
module test_external_expansion_mode_select;
  import xmode_pkg::*;
  typedef struct packed { logic [7:0] wd; pin_mode_t md; } row_t;
  logic        ref_clk = 0, rst = 1, io_wr_byte = 0, io_wr_bit = 0, io_rd = 1;
  logic        bus_cycle_start = 0, bus_drive_data = 1, hold_acknowledge_out = 1, hold_req = 0;
  logic        io_hit, hold_request_in;
  logic [2:0]  io_bit_sel = 0;
  logic [4:0]  reg_sel = 0;
  logic [7:0]  io_wdata = 0, io_rdata;
  logic [15:0] bus_wdata = 16'ha5c3;
  logic [23:0] ext_phys_addr;
  logic [31:0] io_addr = MODE_REG_ADDR, bus_addr = 32'h12b7_5678, data_addr = 32'h12b7_5678;
  logic [31:0] pc_next = 32'hffff_ffff, reg_value = 32'hffff_ffff, pc_fetch, data_addr_ext, reg_operand;
  bus_ctrl_t   bus_ctrl = 8'hf7;
  logic [7:0]  port_latch [4] = '{8'h00, 8'h00, 8'h00, 8'h18};
  logic [7:0]  port_dir_out [4] = '{default: 8'h00};
  logic [7:0]  pin_in [4], pin_out [4], pin_oe [4], port_read [4];
  pin_mode_t   active_mode;
  int          errors = 0, num_checks = 0, n;
  row_t rows [10] = '{'{8'h00, '{1'b0, 1'b0, SPACE_NONE}}, '{8'h03, '{1'b0, 1'b1, SPACE_64K}},
    '{8'h04, '{1'b0, 1'b1, SPACE_256K}}, '{8'h05, '{1'b0, 1'b1, SPACE_1M}}, '{8'h06, '{1'b0, 1'b1, SPACE_4M}},
    '{8'h07, '{1'b0, 1'b1, SPACE_4M}}, '{8'h01, '{1'b0, 1'b0, SPACE_RSVD}}, '{8'h02, '{1'b0, 1'b0, SPACE_RSVD}},
    '{8'hf5, '{1'b0, 1'b1, SPACE_1M}}, '{8'h0b, '{1'b1, 1'b1, SPACE_64K}}};

  always #2.5 ref_clk = ~ref_clk;

  external_expansion_mode_select u_dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_wr_byte(io_wr_byte),
    .io_wr_bit(io_wr_bit), .io_bit_sel(io_bit_sel), .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_hit(io_hit), .bus_cycle_start(bus_cycle_start), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_drive_data(bus_drive_data), .bus_ctrl(bus_ctrl), .hold_acknowledge_out(hold_acknowledge_out),
    .hold_request_in(hold_request_in), .pc_next(pc_next), .pc_fetch(pc_fetch), .data_addr(data_addr),
    .data_addr_ext(data_addr_ext), .ext_phys_addr(ext_phys_addr), .reg_sel(reg_sel), .reg_value(reg_value),
    .reg_operand(reg_operand), .port_latch(port_latch), .port_dir_out(port_dir_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_read(port_read), .active_mode(active_mode));
  ext_bus_model u_model (.ref_clk(ref_clk), .hold_req(hold_req), .pin_out(pin_out), .pin_oe(pin_oe),
                         .pin_in(pin_in));

  function automatic logic [23:0] mask_of(space_t s);
    case (s)
      SPACE_64K:  return MASK_64K;
      SPACE_256K: return MASK_256K;
      SPACE_1M:   return MASK_1M;
      default:    return MASK_4M;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] d, input logic one_bit, input logic [2:0] sel);
    @(posedge ref_clk);
    io_wdata   <= d;
    io_wr_byte <= !one_bit;
    io_wr_bit  <= one_bit;
    io_bit_sel <= sel;
    @(posedge ref_clk);
    io_wr_byte <= 1'b0;
    io_wr_bit  <= 1'b0;
    #1;
  endtask

  task automatic bc();
    @(posedge ref_clk) bus_cycle_start <= 1'b1;
    @(posedge ref_clk) bus_cycle_start <= 1'b0;
    #1;
  endtask

  // The hold request pin passes a synchroniser, so its arrival is waited for.
  task automatic wait_hold(input logic v);
    for (n = 0; n < 8 && hold_request_in !== v; n++) @(posedge ref_clk);
    #1 chk(hold_request_in, v);
    if (n == 8) begin
      errors++;
      tally_and_finish();
    end
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk(io_rdata, MODE_REG_RESET);
    chk(active_mode.expansion, 1'b0);
    for (n = 0; n < 4; n++) chk(pin_oe[n], 8'h00);
    chk(data_addr_ext, 32'hffb7_5678);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].wd, 1'b0, 3'd0);
      bc();
      chk(io_rdata, rows[i].wd & MODE_WR_MASK);
      chk(active_mode[4:3], rows[i].md[4:3]);
      if (rows[i].md.expansion) begin
        chk(active_mode.space, rows[i].md.space);
        chk(ext_phys_addr, data_addr[23:0] & mask_of(rows[i].md.space));
        chk(pin_out[3][7], 1'b1);
      end
    end
    $display("mode table test done");
    chk(pin_out[0], 8'hc3);
    chk(pin_out[1], 8'ha5);
    chk(pin_out[2][1:0], 2'b11);
    chk(pin_out[3][5], 1'b1);
    chk(pin_oe[3][6:5], 2'b01);
    @(posedge ref_clk) hold_req <= 1'b1;
    wait_hold(1'b1);
    chk(port_read[3][6], 1'b1);
    wr(8'h03, 1'b0, 3'd0);
    chk(active_mode.hold_pins_bus, 1'b1);
    bc();
    wait_hold(1'b0);
    chk(pin_out[3][5], 1'b0);
    chk(pin_oe[3][6:5], 2'b00);
    $display("hold pin test done");
    @(posedge ref_clk) rst <= 1'b1;
    @(posedge ref_clk) rst <= 1'b0;
    #1 chk(io_rdata, 8'h00);
    chk(active_mode.expansion, 1'b0);
    wr(8'h01, 1'b1, 3'd2);
    wr(8'h01, 1'b1, 3'd7);
    chk(io_rdata, 8'h04);
    wr(8'h00, 1'b1, 3'd2);
    chk(io_rdata, 8'h00);
    $display("reset and bit write test done");
    @(posedge ref_clk);
    data_addr <= 32'hab7f_fffe;
    reg_sel   <= 5'd1;
    io_addr   <= MODE_REG_ADDR + 32'h0000_0002;
    #1 chk(data_addr_ext, 32'h007f_fffe);
    chk(pc_fetch, 32'h00ff_ffff);
    chk(reg_operand, 32'hffff_ffff);
    chk(io_hit, 1'b0);
    chk(io_rdata, 8'h00);
    @(posedge ref_clk) reg_sel <= 5'd0;
    #1 chk(reg_operand, 32'h0000_0000);
    $display("address test done");
    tally_and_finish();
  end
endmodule
